// File: include/hpad_map.svh
`ifndef HPAD_MAP_SVH
`define HPAD_MAP_SVH

// Host-side base of the system register area.
`define HPAD_HOST_REG_BASE   32'h000D_0000
// Internal processor and DMA base of the system register area.
`define HPAD_INT_REG_BASE    32'h4001_0000
// Span of the system register area decoded behind either base.
`define HPAD_REG_SPAN        32'h0001_0000
// Host-side base of the instruction RAM mirror window.
`define HPAD_MIRROR_BASE     32'h0000_0000
// Mirror window size: 768 Kbytes.
`define HPAD_MIRROR_SIZE     32'h000C_0000
// Top 52 Kbytes of the peripheral register region.
`define HPAD_PERIPH_SIZE     32'h0000_D000
`define HPAD_PERIPH_TOP      32'h000D_0000
`define HPAD_PERIPH_BASE     32'h000C_3000
// Internal base of the mapped peripheral span.
`define HPAD_PERIPH_INT_BASE 32'h4000_3000
// Instruction RAM base as seen internally.
`define HPAD_IRAM_BASE       32'h0000_0000
// Edges the boot-select synchroniser needs before its output is trusted.
`define HPAD_SYNC_FILL       2'h2

`endif

// File: include/hpad_pkg.sv
package hpad_pkg;

    typedef enum logic [1:0] {
        HPAD_BOOT_EXT_MEM,
        HPAD_BOOT_SERIAL,
        HPAD_BOOT_HOST,
        HPAD_BOOT_IRAM
    } hpad_boot_t;

    typedef enum logic [2:0] {
        HPAD_TGT_NONE,
        HPAD_TGT_SYSREG,
        HPAD_TGT_IRAM,
        HPAD_TGT_PERIPH,
        HPAD_TGT_DENIED
    } hpad_tgt_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } hpad_req_t;

    typedef struct packed {
        hpad_tgt_t   target;
        logic [31:0] offset;
    } hpad_dec_t;

endpackage

// File: core/hpad_window.sv
`timescale 1ns/1ns
`include "hpad_map.svh"

// Tests whether an address falls into one window and gives its offset.
module hpad_window #(
    parameter logic [31:0] BASE = 32'h0000_0000,
    parameter logic [31:0] SIZE = 32'h0000_0001
) (
    input  wire logic [31:0] addr_i,
    output logic             hit_o,
    output logic [31:0]      offset_o
);

    assign offset_o = addr_i - BASE;
    assign hit_o    = (addr_i >= BASE) && (offset_o < SIZE);

endmodule

// File: core/hpad_decode.sv
`timescale 1ns/1ns
`include "hpad_map.svh"

// Overview of operation
// R1: Host accesses find system registers at offset plus base D_0000H.
// R2: Processor and DMA find system registers at offset plus 4001_0000H.
// R3: A 768 Kbyte mirror window reaches a target chosen by boot mode.
// R4: Both boot selects low: host port disabled, host accesses reach nothing.
// R5: Upper low, lower high: mirror window reserved, host access denied.
// R6: Upper high: mirror window routes to the instruction RAM.
// R7: Host space maps the top 52 Kbytes of the peripheral region.
// R8: Boot selects are sampled at reset release and held until next reset.
module hpad_decode (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             boot_select_upper_i,
    input  wire logic             boot_select_lower_i,
    input  wire hpad_pkg::hpad_req_t host_req_i,
    input  wire hpad_pkg::hpad_req_t int_req_i,
    output hpad_pkg::hpad_dec_t   host_dec_o,
    output logic                  host_dec_valid_o,
    output hpad_pkg::hpad_dec_t   int_dec_o,
    output logic                  int_dec_valid_o,
    output hpad_pkg::hpad_boot_t  boot_mode_o,
    output logic                  host_port_en_o,
    output logic                  mode_ready_o
);

    // Boot pins come from outside, so they pass two flip-flops first.
    logic [1:0] boot_meta;
    logic [1:0] boot_sync;
    logic       mode_latched;
    hpad_pkg::hpad_boot_t boot_mode;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            boot_meta <= 2'h0;
            boot_sync <= 2'h0;
        end
        else
        begin
            boot_meta <= {boot_select_upper_i, boot_select_lower_i};
            boot_sync <= boot_meta;
        end
    end

    // The mode is caught once, after the synchroniser has filled, and is
    // then frozen so that decoding never shifts under a running system.
    logic [1:0] fill_cnt;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fill_cnt     <= 2'h0;
            mode_latched <= 1'b0;
            boot_mode    <= hpad_pkg::HPAD_BOOT_EXT_MEM;
        end
        else if (!mode_latched)
        begin
            if (fill_cnt == `HPAD_SYNC_FILL)
            begin
                mode_latched <= 1'b1; // [R8]
                boot_mode    <= hpad_pkg::hpad_boot_t'(boot_sync); // [R8]
            end
            else
            begin
                fill_cnt <= fill_cnt + 2'h1;
            end
        end
    end

    assign boot_mode_o    = boot_mode;
    assign mode_ready_o   = mode_latched;
    // Until the mode is known the host port stays shut.
    assign host_port_en_o = mode_latched &&
        (boot_mode != hpad_pkg::HPAD_BOOT_EXT_MEM); // [R4]

    logic        h_reg_hit;
    logic [31:0] h_reg_off;
    logic        h_mir_hit;
    logic [31:0] h_mir_off;
    logic        h_per_hit;
    logic [31:0] h_per_off;
    logic        i_reg_hit;
    logic [31:0] i_reg_off;

    hpad_window #(
        .BASE (`HPAD_HOST_REG_BASE),
        .SIZE (`HPAD_REG_SPAN)
    ) u_host_reg (
        .addr_i   (host_req_i.addr),
        .hit_o    (h_reg_hit),
        .offset_o (h_reg_off)
    );

    hpad_window #(
        .BASE (`HPAD_MIRROR_BASE),
        .SIZE (`HPAD_MIRROR_SIZE)
    ) u_host_mirror (
        .addr_i   (host_req_i.addr),
        .hit_o    (h_mir_hit),
        .offset_o (h_mir_off)
    );

    hpad_window #(
        .BASE (`HPAD_PERIPH_BASE),
        .SIZE (`HPAD_PERIPH_SIZE)
    ) u_host_periph (
        .addr_i   (host_req_i.addr),
        .hit_o    (h_per_hit),
        .offset_o (h_per_off)
    );

    hpad_window #(
        .BASE (`HPAD_INT_REG_BASE),
        .SIZE (`HPAD_REG_SPAN)
    ) u_int_reg (
        .addr_i   (int_req_i.addr),
        .hit_o    (i_reg_hit),
        .offset_o (i_reg_off)
    );

    hpad_pkg::hpad_dec_t next_host_dec;
    hpad_pkg::hpad_dec_t next_int_dec;

    always_comb
    begin
        next_host_dec.target = hpad_pkg::HPAD_TGT_NONE;
        next_host_dec.offset = 32'h0000_0000;
        if (!host_port_en_o)
        begin
            next_host_dec.target = hpad_pkg::HPAD_TGT_NONE; // [R4]
        end
        else if (h_reg_hit)
        begin
            next_host_dec.target = hpad_pkg::HPAD_TGT_SYSREG; // [R1]
            next_host_dec.offset = h_reg_off; // [R1]
        end
        else if (h_mir_hit)
        begin
            unique case (boot_mode)
                hpad_pkg::HPAD_BOOT_SERIAL:
                begin
                    next_host_dec.target = hpad_pkg::HPAD_TGT_DENIED; // [R5]
                end
                hpad_pkg::HPAD_BOOT_HOST,
                hpad_pkg::HPAD_BOOT_IRAM:
                begin
                    next_host_dec.target = hpad_pkg::HPAD_TGT_IRAM; // [R6]
                    next_host_dec.offset = `HPAD_IRAM_BASE + h_mir_off; // [R3]
                end
                hpad_pkg::HPAD_BOOT_EXT_MEM:
                begin
                    next_host_dec.target = hpad_pkg::HPAD_TGT_NONE;
                end
            endcase
        end
        else if (h_per_hit)
        begin
            next_host_dec.target = hpad_pkg::HPAD_TGT_PERIPH; // [R7]
            next_host_dec.offset = `HPAD_PERIPH_INT_BASE + h_per_off; // [R7]
        end
    end

    always_comb
    begin
        next_int_dec.target = hpad_pkg::HPAD_TGT_NONE;
        next_int_dec.offset = 32'h0000_0000;
        if (i_reg_hit)
        begin
            next_int_dec.target = hpad_pkg::HPAD_TGT_SYSREG; // [R2]
            next_int_dec.offset = i_reg_off; // [R2]
        end
    end

    // Results are registered: one cycle from request to decode.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            host_dec_o       <= '0;
            host_dec_valid_o <= 1'b0;
        end
        else
        begin
            host_dec_valid_o <= host_req_i.valid;
            host_dec_o       <= next_host_dec;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            int_dec_o       <= '0;
            int_dec_valid_o <= 1'b0;
        end
        else
        begin
            int_dec_valid_o <= int_req_i.valid;
            int_dec_o       <= next_int_dec;
        end
    end

    host_reg_base_a: assert property ( // [R1]
        @(posedge mclk_i) disable iff (!rst_n_i)
        (host_port_en_o && host_req_i.valid &&
         host_req_i.addr == `HPAD_HOST_REG_BASE + 32'h0000_0010)
        |=> (host_dec_o.target == hpad_pkg::HPAD_TGT_SYSREG &&
             host_dec_o.offset == 32'h0000_0010)
    ) else $error("host register decode wrong");

    int_reg_base_a: assert property ( // [R2]
        @(posedge mclk_i) disable iff (!rst_n_i)
        (int_req_i.valid && int_req_i.addr[31:16] == 16'h4001)
        |=> (int_dec_o.target == hpad_pkg::HPAD_TGT_SYSREG &&
             int_dec_o.offset == {16'h0000, $past(int_req_i.addr[15:0])})
    ) else $error("internal register decode wrong");

    mirror_size_a: assert property ( // [R3]
        @(posedge mclk_i) disable iff (!rst_n_i)
        (host_req_i.addr == 32'h000C_0000)
        |=> (host_dec_o.target != hpad_pkg::HPAD_TGT_IRAM)
    ) else $error("mirror window too large");

    port_off_a: assert property ( // [R4]
        @(posedge mclk_i) disable iff (!rst_n_i)
        (boot_mode == hpad_pkg::HPAD_BOOT_EXT_MEM)
        |=> (host_dec_o.target == hpad_pkg::HPAD_TGT_NONE)
    ) else $error("host access with port disabled");

    mirror_denied_a: assert property ( // [R5]
        @(posedge mclk_i) disable iff (!rst_n_i)
        (mode_latched && boot_mode == hpad_pkg::HPAD_BOOT_SERIAL &&
         host_req_i.addr < `HPAD_MIRROR_SIZE)
        |=> (host_dec_o.target == hpad_pkg::HPAD_TGT_DENIED)
    ) else $error("reserved mirror not denied");

    mirror_iram_a: assert property ( // [R6]
        @(posedge mclk_i) disable iff (!rst_n_i)
        (mode_latched && boot_mode[1] && host_req_i.addr < `HPAD_MIRROR_SIZE)
        |=> (host_dec_o.target == hpad_pkg::HPAD_TGT_IRAM &&
             host_dec_o.offset == $past(host_req_i.addr))
    ) else $error("mirror not routed to instruction RAM");

    periph_top_a: assert property ( // [R7]
        @(posedge mclk_i) disable iff (!rst_n_i)
        (host_port_en_o && host_req_i.addr == `HPAD_PERIPH_TOP - 32'h4)
        |=> (host_dec_o.target == hpad_pkg::HPAD_TGT_PERIPH)
    ) else $error("peripheral top not mapped");

    mode_hold_a: assert property ( // [R8]
        @(posedge mclk_i) disable iff (!rst_n_i)
        mode_latched |=> (mode_latched && $stable(boot_mode))
    ) else $error("boot mode changed after capture");

endmodule

// File: verif/hpad_host_mcu.sv
`timescale 1ns/1ns

// Behavioural external microcontroller on the parallel host bus.
module hpad_host_mcu (
    input  wire logic          mclk_i,
    output hpad_pkg::hpad_req_t host_req_o
);
    logic [31:0] last_addr;

    initial
    begin
        host_req_o = {1'b0, 32'h0000_0000};
        last_addr  = 32'h0000_0000;
    end

    // Drives one request at a falling edge and holds it past the next
    // rising edge, so back-to-back calls give one request per cycle.
    task automatic issue(input logic [31:0] a);
        host_req_o = {1'b1, a};
        last_addr  = a;
        @(negedge mclk_i);
    endtask

    // A released bus shows the inverse of the last address, never a
    // stale copy that could mask a decode that ignores the valid bit.
    task automatic idle();
        host_req_o = {1'b0, ~last_addr};
    endtask
endmodule

// File: verif/tb_host_port_address_decode.sv
`timescale 1ns/1ns

`define CHK(nm, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("ERROR %s exp %0h got %0h", nm, e, g); \
        end \
    end

module tb_host_port_address_decode;
    logic                 mclk_i;
    logic                 rst_n_i;
    logic                 up;
    logic                 lo;
    hpad_pkg::hpad_req_t  host_req;
    hpad_pkg::hpad_req_t  int_req;
    hpad_pkg::hpad_dec_t  host_dec;
    hpad_pkg::hpad_dec_t  int_dec;
    logic                 host_dec_valid_o;
    logic                 int_dec_valid_o;
    hpad_pkg::hpad_boot_t boot_mode_o;
    logic                 host_port_en_o;
    logic                 mode_ready_o;
    int                   err_total;
    int                   checks;
    int                   cycles;

    hpad_decode u_hpad_decode (
        .mclk_i              (mclk_i),
        .rst_n_i             (rst_n_i),
        .boot_select_upper_i (up),
        .boot_select_lower_i (lo),
        .host_req_i          (host_req),
        .int_req_i           (int_req),
        .host_dec_o          (host_dec),
        .host_dec_valid_o    (host_dec_valid_o),
        .int_dec_o           (int_dec),
        .int_dec_valid_o     (int_dec_valid_o),
        .boot_mode_o         (boot_mode_o),
        .host_port_en_o      (host_port_en_o),
        .mode_ready_o        (mode_ready_o)
    );

    hpad_host_mcu u_hpad_host_mcu (
        .mclk_i     (mclk_i),
        .host_req_o (host_req)
    );

    task automatic tally_and_finish();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Offsets of NONE and DENIED carry no meaning, so they are not checked.
    task automatic host_chk(input logic [31:0] a,
                            input hpad_pkg::hpad_tgt_t t,
                            input logic [31:0] o);
        u_hpad_host_mcu.issue(a);
        `CHK("host_valid", 1'b1, host_dec_valid_o)
        `CHK("host_target", t, host_dec.target)
        if (t inside {hpad_pkg::HPAD_TGT_SYSREG, hpad_pkg::HPAD_TGT_IRAM,
                      hpad_pkg::HPAD_TGT_PERIPH})
            `CHK("host_offset", o, host_dec.offset)
    endtask

    task automatic int_chk(input logic [31:0] a,
                           input hpad_pkg::hpad_tgt_t t,
                           input logic [31:0] o);
        int_req = {1'b1, a};
        @(negedge mclk_i);
        `CHK("int_valid", 1'b1, int_dec_valid_o)
        `CHK("int_target", t, int_dec.target)
        if (t == hpad_pkg::HPAD_TGT_SYSREG)
            `CHK("int_offset", o, int_dec.offset)
    endtask

    task automatic boot(input logic u, input logic l);
        @(negedge mclk_i);
        rst_n_i = 1'b0;
        up = u;
        lo = l;
        repeat (6) @(negedge mclk_i);
        rst_n_i = 1'b1;
        host_chk(32'h000D_0010, hpad_pkg::HPAD_TGT_NONE, 32'h0);
        `CHK("ready_early", 1'b0, mode_ready_o)
        u_hpad_host_mcu.idle();
        repeat (2) @(negedge mclk_i);
        `CHK("ready", 1'b1, mode_ready_o)
        `CHK("boot_mode", {u, l}, boot_mode_o)
        `CHK("port_en", u | l, host_port_en_o)
    endtask

    task automatic t_ext_mem_boot();
        boot(1'b0, 1'b0);
        host_chk(32'h000D_0010, hpad_pkg::HPAD_TGT_NONE, 32'h0);
        host_chk(32'h0000_0100, hpad_pkg::HPAD_TGT_NONE, 32'h0);
        u_hpad_host_mcu.idle();
        int_chk(32'h4001_0010, hpad_pkg::HPAD_TGT_SYSREG, 32'h10);
        `CHK("host_idle", 1'b0, host_dec_valid_o)
        int_chk(32'h000D_0010, hpad_pkg::HPAD_TGT_NONE, 32'h0);
        int_req = {1'b0, 32'hBFFE_FFEF};
    endtask

    task automatic t_serial_boot();
        boot(1'b0, 1'b1);
        host_chk(32'h000B_FFFC, hpad_pkg::HPAD_TGT_DENIED, 32'h0);
        host_chk(32'h000D_0004, hpad_pkg::HPAD_TGT_SYSREG, 32'h4);
        host_chk(32'h000C_3000, hpad_pkg::HPAD_TGT_PERIPH,
                 32'h4000_3000);
        u_hpad_host_mcu.idle();
    endtask

    task automatic t_host_boot();
        boot(1'b1, 1'b0);
        host_chk(32'h000B_FFFC, hpad_pkg::HPAD_TGT_IRAM, 32'hB_FFFC);
        host_chk(32'h000C_0000, hpad_pkg::HPAD_TGT_NONE, 32'h0);
        host_chk(32'h000C_2FFC, hpad_pkg::HPAD_TGT_NONE, 32'h0);
        host_chk(32'h000C_FFFC, hpad_pkg::HPAD_TGT_PERIPH,
                 32'h4000_FFFC);
        host_chk(32'h000D_FFFC, hpad_pkg::HPAD_TGT_SYSREG, 32'hFFFC);
        host_chk(32'h000D_0010, hpad_pkg::HPAD_TGT_SYSREG, 32'h10);
        host_chk(32'h000E_0000, hpad_pkg::HPAD_TGT_NONE, 32'h0);
        u_hpad_host_mcu.idle();
        int_chk(32'h4001_FFFC, hpad_pkg::HPAD_TGT_SYSREG, 32'hFFFC);
        int_chk(32'h4002_0000, hpad_pkg::HPAD_TGT_NONE, 32'h0);
        int_req = {1'b0, 32'hBFFD_FFFF};
        @(negedge mclk_i);
        `CHK("int_idle", 1'b0, int_dec_valid_o)
    endtask

    task automatic t_iram_boot_hold();
        boot(1'b1, 1'b1);
        host_chk(32'h0000_0000, hpad_pkg::HPAD_TGT_IRAM, 32'h0);
        u_hpad_host_mcu.idle();
        up = 1'b0;
        lo = 1'b0;
        repeat (4) @(negedge mclk_i);
        `CHK("held_mode", hpad_pkg::HPAD_BOOT_IRAM, boot_mode_o)
        `CHK("held_port_en", 1'b1, host_port_en_o)
        host_chk(32'h0000_0040, hpad_pkg::HPAD_TGT_IRAM, 32'h40);
        u_hpad_host_mcu.idle();
    endtask

    initial
    begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    // The whole run needs about 63 cycles; 1000 leaves a wide margin.
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    initial
    begin
        err_total = 0;
        checks    = 0;
        cycles    = 0;
        rst_n_i   = 1'b0;
        up        = 1'b0;
        lo        = 1'b0;
        int_req   = {1'b0, 32'h0000_0000};
        t_ext_mem_boot();
        t_serial_boot();
        t_host_boot();
        t_iram_boot_hold();
        tally_and_finish();
    end
endmodule
